// File: adcc_pkg.sv
/*
  Shared constants and carrier types of the converter configuration bank.
  Assumes a single 50 MHz system clock and an active-low async reset.
*/
`default_nettype none
package adcc_pkg;
  // Register offsets on the serial write port
  localparam logic [7:0] ADDR_TIMING = 8'h62;
  localparam logic [7:0] ADDR_POWER = 8'h63;
  localparam logic [7:0] ADDR_SOURCE = 8'h65;
  localparam logic [7:0] ADDR_GAIN = 8'h68;
  localparam logic [7:0] ADDR_USER_LO = 8'h69;
  localparam logic [7:0] ADDR_USER_HI = 8'h6A;
  localparam logic [7:0] ADDR_IFACE = 8'h6C;
  // Field positions
  localparam int PHASE_LSB = 0;
  localparam int SHIFT_LSB = 5;
  localparam int FMT_BIT = 3;
  localparam int SLOW_BIT = 4;
  localparam int PDN_BIT = 7;
  localparam int PAT_LSB = 5;
  localparam int GAIN_LSB = 0;
  localparam int CLEAR_BIT = 1;
  localparam int STYLE_LSB = 3;
  // Reset values
  localparam logic [4:0] RST_PHASE = 5'h01;
  localparam logic [1:0] RST_SHIFT = 2'h0;
  localparam logic [2:0] RST_PAT = 3'h0;
  localparam logic [3:0] RST_GAIN = 4'h8;
  localparam logic [1:0] RST_STYLE = 2'h0;
  localparam logic [13:0] RST_USER = 14'h0000;
  // Output source codes
  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_ZEROS = 3'h1;
  localparam logic [2:0] PAT_ONES = 3'h2;
  localparam logic [2:0] PAT_TOGGLE = 3'h3;
  localparam logic [2:0] PAT_RAMP = 3'h4;
  localparam logic [2:0] PAT_USER = 3'h5;
  // Pattern words
  localparam logic [13:0] TOGGLE_A = 14'h2AAA;
  localparam logic [13:0] TOGGLE_B = 14'h1555;
  localparam logic [13:0] RAMP_START = 14'h0000;
  localparam logic [13:0] ALL_ONES = 14'h3FFF;
  localparam logic [13:0] MSB_FLIP = 14'h2000;
  // Bus style, gain range, setup shifts in 36ths of a sample period
  localparam logic [1:0] STYLE_CMOS = 2'h3;
  localparam logic [3:0] GAIN_BASE = 4'h8;
  localparam logic [3:0] GAIN_MAX = 4'hE;
  localparam logic signed [3:0] SETUP_POS2 = 4'sh2;
  localparam logic signed [3:0] SETUP_POS3 = 4'sh5;
  localparam logic signed [3:0] SETUP_POS4 = 4'shA;
  // Serial frame length in bits
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // Decoded configuration bundle
  typedef struct packed {
    logic [4:0] clkPhase;
    logic [1:0] wordShift;
    logic offsetBinary;
    logic slowMode;
    logic powerDown;
    logic [2:0] patSel;
    logic [3:0] gainCode;
    logic [13:0] userPattern;
    logic [1:0] busStyle;
  } adcc_cfg_type;

  // Output timing placement bundle
  typedef struct packed {
    logic [1:0] cmosClkLate12;
    logic lvdsClkEarly12;
    logic lvdsClkAligned;
    logic signed [3:0] setupDelta36;
  } adcc_tim_type;
endpackage : adcc_pkg
`default_nettype wire

// File: adcc_pattern_gen.sv
/*
  Output data path: picks conversion results or a test pattern and
  applies the number format. Assumes sampleValid marks one output
  clock cycle and sampleData is two's complement from the core.
*/
`default_nettype none
module adcc_pattern_gen (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire adcc_pkg::adcc_cfg_type cfg,
  input wire logic sampleValid,
  input wire logic [13:0] sampleData,
  output logic [13:0] outData,
  output logic outValid,
  output logic outDataOe
);
  // Ramp count and toggle phase
  logic [13:0] ramp_r;
  logic togglePh_r;
  // Selected word for this sample
  logic [13:0] word_nxt;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ramp_r <= adcc_pkg::RAMP_START;
    end else if (cfg.patSel != adcc_pkg::PAT_RAMP) begin
      // Restart from zero whenever ramp is not selected
      ramp_r <= adcc_pkg::RAMP_START;
    end else if (sampleValid) begin
      ramp_r <= ramp_r + 14'h0001;
    end
  end

  // toggle phase flips per output clock
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      togglePh_r <= 1'b0;
    end else if (sampleValid) begin
      togglePh_r <= ~togglePh_r;
    end
  end

  always_comb begin
    case (cfg.patSel)
      adcc_pkg::PAT_NORMAL: begin
        word_nxt = cfg.offsetBinary ?
          (sampleData ^ adcc_pkg::MSB_FLIP) : sampleData;
      end
      adcc_pkg::PAT_ZEROS: word_nxt = 14'h0000;
      adcc_pkg::PAT_ONES: word_nxt = adcc_pkg::ALL_ONES;
      adcc_pkg::PAT_TOGGLE: begin
        word_nxt = togglePh_r ? adcc_pkg::TOGGLE_B : adcc_pkg::TOGGLE_A;
      end
      adcc_pkg::PAT_RAMP: word_nxt = ramp_r;
      adcc_pkg::PAT_USER: word_nxt = cfg.userPattern;
      // Unused codes drive zeros
      default: word_nxt = 14'h0000;
    endcase
  end

  // Output register; power down silences the buffers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      outData <= 14'h0000;
      outValid <= 1'b0;
      outDataOe <= 1'b0;
    end else begin
      outValid <= sampleValid & ~cfg.powerDown;
      outDataOe <= ~cfg.powerDown;
      if (sampleValid) begin
        outData <= word_nxt;
      end
    end
  end

  toggle_alt_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cfg.patSel == adcc_pkg::PAT_TOGGLE) && sampleValid ##1
    (cfg.patSel == adcc_pkg::PAT_TOGGLE) && sampleValid |=>
    outData == ~$past(outData) && outData[0] != outData[1])
    else $error("toggle pattern did not alternate");
  ramp_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(cfg.patSel == adcc_pkg::PAT_RAMP) && sampleValid &&
    (cfg.patSel == adcc_pkg::PAT_RAMP) ##1 sampleValid &&
    (cfg.patSel == adcc_pkg::PAT_RAMP) |=>
    outData == $past(outData) + 14'h0001)
    else $error("ramp did not step by one");
endmodule : adcc_pattern_gen
`default_nettype wire

// File: adcc_config_regs.sv
/*
  Configuration register bank written over the three-wire serial port,
  with the output timing decode and the output data path.
  Assumes senN, sclk and sdata are already synchronous to sys_clk and
  that sclk is slow enough for each level to last at least one cycle.
*/
`default_nettype none
module adcc_config_regs (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic senN,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic sampleValid,
  input wire logic [13:0] sampleData,
  output adcc_pkg::adcc_cfg_type cfg,
  output adcc_pkg::adcc_tim_type timing,
  output logic [2:0] gainDb,
  output logic [13:0] outData,
  output logic outValid,
  output logic outDataOe
);
  // Previous serial clock level for edge finding
  logic sclkPrev_r;
  // Bits received in this frame
  logic [4:0] bitCnt_r;
  // Frame shift register, address then data
  logic [15:0] shift_r;
  // Rising serial clock inside a frame
  logic sclkRise;
  // Last bit of a frame arrives
  logic frameDone;
  // Completed frame word
  logic [15:0] frameWord;
  // Decoded address and data
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  // Software clear request
  logic softClear;
  // Field registers
  logic [4:0] clkPhase_r;
  logic [1:0] wordShift_r;
  logic offsetBinary_r;
  logic slowMode_r;
  logic powerDown_r;
  logic [2:0] patSel_r;
  logic [3:0] gainCode_r;
  logic [7:0] userLow_r;
  logic [5:0] userHigh_r;
  logic [1:0] busStyle_r;
  // CMOS bus selected
  logic cmosMode;

  // Serial edge detection
  assign sclkRise = sclk & ~sclkPrev_r & ~senN;
  assign frameDone = sclkRise && (bitCnt_r == adcc_pkg::FRAME_BITS - 5'h01);
  assign frameWord = {shift_r[14:0], sdata};
  assign wrAddr = frameWord[15:8];
  assign wrData = frameWord[7:0];
  assign softClear = frameDone && (wrAddr == adcc_pkg::ADDR_IFACE) &&
    wrData[adcc_pkg::CLEAR_BIT];

  // Serial clock history
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclkPrev_r <= 1'b0;
    end else begin
      sclkPrev_r <= sclk;
    end
  end

  // Frame bit counter and shifter; extra bits are ignored
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bitCnt_r <= 5'h00;
      shift_r <= 16'h0000;
    end else if (senN) begin
      // Frame ends or idles
      bitCnt_r <= 5'h00;
    end else if (sclkRise && bitCnt_r < adcc_pkg::FRAME_BITS) begin
      bitCnt_r <= bitCnt_r + 5'h01;
      shift_r <= frameWord;
    end
  end

  // Timing register: phase, word shift
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clkPhase_r <= adcc_pkg::RST_PHASE;
      wordShift_r <= adcc_pkg::RST_SHIFT;
    end else if (softClear) begin
      clkPhase_r <= adcc_pkg::RST_PHASE;
      wordShift_r <= adcc_pkg::RST_SHIFT;
    end else if (frameDone && wrAddr == adcc_pkg::ADDR_TIMING) begin
      clkPhase_r <= wrData[adcc_pkg::PHASE_LSB +: 5];
      wordShift_r <= wrData[adcc_pkg::SHIFT_LSB +: 2];
    end
  end

  // Power and format register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      offsetBinary_r <= 1'b0;
      slowMode_r <= 1'b0;
      powerDown_r <= 1'b0;
    end else if (softClear) begin
      offsetBinary_r <= 1'b0;
      slowMode_r <= 1'b0;
      powerDown_r <= 1'b0;
    end else if (frameDone && wrAddr == adcc_pkg::ADDR_POWER) begin
      offsetBinary_r <= wrData[adcc_pkg::FMT_BIT];
      slowMode_r <= wrData[adcc_pkg::SLOW_BIT];
      powerDown_r <= wrData[adcc_pkg::PDN_BIT];
    end
  end

  // Source select register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      patSel_r <= adcc_pkg::RST_PAT;
    end else if (softClear) begin
      patSel_r <= adcc_pkg::RST_PAT;
    end else if (frameDone && wrAddr == adcc_pkg::ADDR_SOURCE) begin
      patSel_r <= wrData[adcc_pkg::PAT_LSB +: 3];
    end
  end

  // Gain register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gainCode_r <= adcc_pkg::RST_GAIN;
    end else if (softClear) begin
      gainCode_r <= adcc_pkg::RST_GAIN;
    end else if (frameDone && wrAddr == adcc_pkg::ADDR_GAIN) begin
      gainCode_r <= wrData[adcc_pkg::GAIN_LSB +: 4];
    end
  end

  // User pattern registers: low byte, high bits
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      userLow_r <= adcc_pkg::RST_USER[7:0];
      userHigh_r <= adcc_pkg::RST_USER[13:8];
    end else if (softClear) begin
      userLow_r <= adcc_pkg::RST_USER[7:0];
      userHigh_r <= adcc_pkg::RST_USER[13:8];
    end else if (frameDone && wrAddr == adcc_pkg::ADDR_USER_LO) begin
      userLow_r <= wrData;
    end else if (frameDone && wrAddr == adcc_pkg::ADDR_USER_HI) begin
      // upper bits expected zero, not stored
      userHigh_r <= wrData[5:0];
    end
  end

  // Interface register: bus style; clear bit is not stored
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busStyle_r <= adcc_pkg::RST_STYLE;
    end else if (softClear) begin
      busStyle_r <= adcc_pkg::RST_STYLE;
    end else if (frameDone && wrAddr == adcc_pkg::ADDR_IFACE) begin
      busStyle_r <= wrData[adcc_pkg::STYLE_LSB +: 2];
    end
  end

  // Configuration bundle out
  always_comb begin
    cfg.clkPhase = clkPhase_r;
    cfg.wordShift = wordShift_r;
    cfg.offsetBinary = offsetBinary_r;
    cfg.slowMode = slowMode_r;
    cfg.powerDown = powerDown_r;
    cfg.patSel = patSel_r;
    cfg.gainCode = gainCode_r;
    cfg.userPattern = {userHigh_r, userLow_r};
    cfg.busStyle = busStyle_r;
  end

  // mode that picks the timing behaviour
  assign cmosMode = (busStyle_r == adcc_pkg::STYLE_CMOS);

  // Clock placement decode; low-bit forms win on overlap
  always_comb begin
    timing.cmosClkLate12 = 2'd0;
    timing.lvdsClkEarly12 = 1'b0;
    timing.lvdsClkAligned = 1'b0;
    if (clkPhase_r[2:0] == 3'b011 ||
        (clkPhase_r[0] && clkPhase_r[2:0] != 3'b101 &&
         clkPhase_r[2:0] != 3'b111 && clkPhase_r[4:3] == 2'b01)) begin
      timing.cmosClkLate12 = cmosMode ? 2'd1 : 2'd0;
      timing.lvdsClkEarly12 = ~cmosMode;
    end else if (clkPhase_r[2:0] == 3'b101 ||
        (clkPhase_r[0] && clkPhase_r[2:0] != 3'b111 &&
         clkPhase_r[4:3] == 2'b10)) begin
      timing.cmosClkLate12 = cmosMode ? 2'd3 : 2'd0;
      timing.lvdsClkAligned = ~cmosMode;
    end else if (clkPhase_r[2:0] == 3'b111 ||
        (clkPhase_r[0] && clkPhase_r[4:3] == 2'b11)) begin
      timing.cmosClkLate12 = cmosMode ? 2'd2 : 2'd0;
      timing.lvdsClkAligned = ~cmosMode;
    end
    case (cmosMode ? wordShift_r : 2'b00)
      2'b01: timing.setupDelta36 = adcc_pkg::SETUP_POS2;
      2'b10: timing.setupDelta36 = adcc_pkg::SETUP_POS3;
      2'b11: timing.setupDelta36 = adcc_pkg::SETUP_POS4;
      default: timing.setupDelta36 = 4'sh0;
    endcase
  end

  // gain in dB; codes out of range read as 0 dB
  always_comb begin
    if (gainCode_r >= adcc_pkg::GAIN_BASE &&
        gainCode_r <= adcc_pkg::GAIN_MAX) begin
      gainDb = 3'(gainCode_r - adcc_pkg::GAIN_BASE);
    end else begin
      gainDb = 3'd0;
    end
  end

  // Output data path
  adcc_pattern_gen dataPath (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .cfg(cfg),
    .sampleValid(sampleValid),
    .sampleData(sampleData),
    .outData(outData),
    .outValid(outValid),
    .outDataOe(outDataOe)
  );

  // Clear restores phase, gain, source, style, power-down and user fields
  soft_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    softClear |=> clkPhase_r == adcc_pkg::RST_PHASE &&
    gainCode_r == adcc_pkg::RST_GAIN && patSel_r == 3'h0 &&
    busStyle_r == 2'h0 && !powerDown_r && cfg.userPattern == 14'h0000)
    else $error("clear left a field set");
  // Whole register taken in one write
  timing_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    frameDone && !softClear && wrAddr == adcc_pkg::ADDR_TIMING |=>
    {wordShift_r, clkPhase_r} == $past(wrData[6:0]))
    else $error("timing write not taken whole");
  // Default phase gives nominal placement
  phase_nominal_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkPhase_r == 5'h01 |-> timing.cmosClkLate12 == 2'd0 &&
    !timing.lvdsClkEarly12 && !timing.lvdsClkAligned)
    else $error("default phase not nominal");
  // One twelfth codes
  phase_one12_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkPhase_r[2:0] == 3'b011 |-> (cmosMode ?
    timing.cmosClkLate12 == 2'd1 : timing.lvdsClkEarly12))
    else $error("one twelfth decode wrong");
  // Three twelfths codes
  phase_three12_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkPhase_r[2:0] == 3'b101 |-> (cmosMode ?
    timing.cmosClkLate12 == 2'd3 : timing.lvdsClkAligned))
    else $error("three twelfths decode wrong");
  // Two twelfths codes
  phase_two12_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkPhase_r == 5'b11001 |-> (cmosMode ?
    timing.cmosClkLate12 == 2'd2 : timing.lvdsClkAligned))
    else $error("two twelfths decode wrong");
  // Word shift has no effect outside CMOS
  shift_cmos_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !cmosMode |-> timing.setupDelta36 == 4'sh0)
    else $error("word shift applied off CMOS");
  // Word shift amounts
  shift_amount_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmosMode && wordShift_r == 2'b11 |-> timing.setupDelta36 == -4'sd6)
    else $error("setup shift amount wrong");
  // Offset format flips the sign bit only
  format_msb_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    sampleValid && patSel_r == 3'h0 && offsetBinary_r |=>
    outData == ($past(sampleData) ^ 14'h2000))
    else $error("format conversion wrong");
  // Power down removes drive
  power_down_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    powerDown_r |=> !outDataOe && !outValid)
    else $error("outputs active in power down");
  // Fixed patterns
  fixed_pat_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    sampleValid && patSel_r inside {3'h1, 3'h2} |=>
    outData == ($past(patSel_r) == 3'h1 ? 14'h0000 : 14'h3FFF))
    else $error("fixed pattern wrong");
  // User pattern output
  user_pat_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    sampleValid && patSel_r == 3'h5 |=>
    outData == {$past(userHigh_r), $past(userLow_r)})
    else $error("user pattern wrong");
  // Gain mapping
  gain_map_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    gainCode_r == 4'hE |-> gainDb == 3'd6)
    else $error("gain mapping wrong");
endmodule : adcc_config_regs
`default_nettype wire

// File: adcc_host_model.sv
/*
  Host model: writes configuration frames over the three-wire port.
  Assumes the bank samples senN, sclk and sdata on rising sys_clk.
*/
`default_nettype none
module adcc_host_model (
  input wire logic sys_clk,
  output logic senN,
  output logic sclk,
  output logic sdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle port: deselected, serial clock parked low
  initial begin
    senN = 1'b1;
    sclk = 1'b0;
    sdata = 1'b0;
  end

  function automatic logic [7:0] used_bits(input logic [7:0] addr);
    case (addr)
      8'h62: used_bits = 8'h7F;
      8'h63: used_bits = 8'h98;
      8'h65: used_bits = 8'hE0;
      8'h68: used_bits = 8'h0F;
      8'h6A: used_bits = 8'h3F;
      8'h6C: used_bits = 8'h1A;
      default: used_bits = 8'hFF;
    endcase
  endfunction : used_bits

  task automatic send(input logic [7:0] addr, input logic [7:0] data);
    logic [15:0] frame;
    frame = {addr, data & used_bits(addr)};
    @(negedge sys_clk);
    senN = 1'b0;
    // Address first, then data, MSB first
    for (int i = 15; i >= 0; i--) begin
      @(negedge sys_clk);
      sdata = frame[i];
      @(negedge sys_clk);
      sclk = 1'b1;
      @(negedge sys_clk);
      sclk = 1'b0;
    end
    @(negedge sys_clk);
    senN = 1'b1;
    // Released line shows the inverse of its last level
    sdata = ~sdata;
    @(negedge sys_clk);
  endtask : send
endmodule : adcc_host_model
`default_nettype wire

// File: tb_top.sv
/*
  Self-checking bench for the configuration bank and data path.
  Assumes the host model drives the serial port; samples come from here.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Phase codes and their expected placements
  localparam logic [4:0] PHS [0:6] = '{5'h01, 5'h03, 5'h05, 5'h07,
    5'h09, 5'h11, 5'h19};
  localparam logic [1:0] LATE [0:6] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h1,
    2'h3, 2'h2};
  localparam logic [6:0] EARLY = 7'b0010010;
  localparam logic [6:0] ALIGN = 7'b1101100;
  // Setup change per word shift code, in 36ths
  localparam logic [3:0] SETUP [0:3] = '{4'h0, 4'h2, 4'h5, 4'hA};
  // Source codes with a fixed expected word
  localparam logic [2:0] PCODE [0:2] = '{3'h1, 3'h2, 3'h5};
  localparam logic [13:0] PWORD [0:2] = '{14'h0000, 14'h3FFF, 14'h3F34};

  logic sys_clk;
  logic rstn;
  logic senN;
  logic sclk;
  logic sdata;
  logic sampleValid;
  logic [13:0] sampleData;
  adcc_pkg::adcc_cfg_type cfg;
  adcc_pkg::adcc_cfg_type cfgSaved;
  adcc_pkg::adcc_tim_type timing;
  logic [2:0] gainDb;
  logic [13:0] outData;
  logic outValid;
  logic outDataOe;
  int failCount;
  int checkCount;
  // Captured output words and strobes
  logic [13:0] got [0:3];
  logic gotV [0:3];

  // Design under test
  adcc_config_regs uut (
    .sys_clk(sys_clk), .rstn(rstn), .senN(senN), .sclk(sclk),
    .sdata(sdata), .sampleValid(sampleValid), .sampleData(sampleData),
    .cfg(cfg), .timing(timing), .gainDb(gainDb), .outData(outData),
    .outValid(outValid), .outDataOe(outDataOe)
  );

  // Serial host
  adcc_host_model host (
    .sys_clk(sys_clk), .senN(senN), .sclk(sclk), .sdata(sdata)
  );

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Compares one value and counts it
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] expv);
    checkCount++;
    if (seen !== expv) begin
      failCount++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  // Sends n back-to-back samples; each answer is taken while it stands
  task automatic run(input int n, input logic [13:0] dat);
    for (int i = 0; i < n; i++) begin
      sampleValid = 1'b1;
      sampleData = dat;
      @(negedge sys_clk);
      got[i] = outData;
      gotV[i] = outValid;
    end
    sampleValid = 1'b0;
  endtask : run

  // Prints counts and verdict, ends the run
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    failCount++;
    close_out();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    sampleValid = 1'b0;
    sampleData = 14'h0000;
    failCount = 0;
    checkCount = 0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    // Defaults after reset
    check("phase", 16'(cfg.clkPhase), 16'h0001);
    check("shift", 16'(cfg.wordShift), 16'h0000);
    check("gain", 16'(cfg.gainCode), 16'h0008);
    check("style", 16'(cfg.busStyle), 16'h0000);
    check("oe", 16'(outDataOe), 16'h0001);
    // Single-ended mode: clock delay and data shift
    host.send(8'h6C, 8'h18);
    for (int i = 0; i < 7; i++) begin
      host.send(8'h62, {1'b0, 2'(i % 4), PHS[i]});
      check("late", 16'(timing.cmosClkLate12), 16'(LATE[i]));
      check("setup", {12'h000, timing.setupDelta36},
        {12'h000, SETUP[i % 4]});
    end
    // Differential mode: earlier or aligned, no data shift
    host.send(8'h6C, 8'h08);
    for (int i = 0; i < 7; i++) begin
      host.send(8'h62, {1'b0, 2'(i % 4), PHS[i]});
      check("early", 16'(timing.lvdsClkEarly12), 16'(EARLY[i]));
      check("align", 16'(timing.lvdsClkAligned), 16'(ALIGN[i]));
      check("nosetup", 16'(timing.setupDelta36), 16'h0000);
    end
    // Number format and slow mode in one write
    run(1, 14'h1FFF);
    check("twos", 16'(got[0]), 16'h1FFF);
    host.send(8'h63, 8'h18);
    check("slow", 16'(cfg.slowMode), 16'h0001);
    run(1, 14'h1FFF);
    check("offset", 16'(got[0]), 16'h3FFF);
    check("valid", 16'(gotV[0]), 16'h0001);
    // Power down silences the outputs, then recovers
    host.send(8'h63, 8'h80);
    run(1, 14'h0123);
    check("pdvalid", 16'(gotV[0]), 16'h0000);
    check("pdoe", 16'(outDataOe), 16'h0000);
    host.send(8'h63, 8'h00);
    check("upoe", 16'(outDataOe), 16'h0001);
    // User pattern words
    host.send(8'h69, 8'h34);
    host.send(8'h6A, 8'h3F);
    check("user", 16'(cfg.userPattern), 16'h3F34);
    // Fixed-word sources
    for (int p = 0; p < 3; p++) begin
      host.send(8'h65, {PCODE[p], 5'h00});
      run(1, 14'h1234);
      check("pattern", 16'(got[0]), 16'(PWORD[p]));
    end
    // Toggle pattern: checkerboard, complemented next word
    host.send(8'h65, 8'h60);
    run(2, 14'h1234);
    check("tog0", 16'((got[0] === 14'h2AAA) || (got[0] === 14'h1555)),
      16'h0001);
    check("tog1", 16'(got[1]), 16'(got[0] ^ 14'h3FFF));
    // Ramp from zero, one step per sample
    host.send(8'h65, 8'h80);
    run(3, 14'h1234);
    for (int k = 0; k < 3; k++) begin
      check("ramp", 16'(got[k]), 16'(k));
    end
    // Every in-range gain code, 8 to 14
    for (int g = 8; g <= 14; g++) begin
      host.send(8'h68, 8'(g));
      check("gaindb", 16'(gainDb), 16'(g - 8));
    end
    // Unmapped address leaves the bank alone
    cfgSaved = cfg;
    host.send(8'h64, 8'hFF);
    check("unmapped", 16'(cfg !== cfgSaved), 16'h0000);
    // Software clear restores defaults
    host.send(8'h6C, 8'h02);
    check("clrphase", 16'(cfg.clkPhase), 16'h0001);
    check("clrgain", 16'(cfg.gainCode), 16'h0008);
    check("clruser", 16'(cfg.userPattern), 16'h0000);
    check("clrpat", 16'(cfg.patSel), 16'h0000);
    check("clrstyle", 16'(cfg.busStyle), 16'h0000);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
